// ---- pkg/mfp_map.vh ----
// Constants for the message field packer: widths, field layout, bit order.
// Assumes inclusion by bare name from the design files under hdl/.
`ifndef MFP_MAP_VH
`define MFP_MAP_VH

// ==========================================================
// Field request port
`define MFP_FIELD_W 32
`define MFP_LEN_W 6
`define MFP_KIND_W 2

// ==========================================================
// Field kinds carried with each request
`define MFP_KIND_HDR 2'h0
`define MFP_KIND_MSG 2'h1

// ==========================================================
// Serialiser bit order selections
`define MFP_ORDER_LSB 1'h0
`define MFP_ORDER_MSB 1'h1

// ==========================================================
// Octet layout
`define MFP_OCTET_W 8
`define MFP_BITPOS_W 3
`define MFP_OCTNUM_W 16

`endif

// ---- hdl/mfp_serialiser.v ----
// Octet serialiser: shifts each octet out over eight clock-enabled cycles after a one-cycle load.
// Assumes the packer offers one octet at a time with valid and ready.
`timescale 1ns/1ns
`include "mfp_map.vh"

module mfp_serialiser (
    input wire clk,
    input wire rst,
    input wire ce,
    input wire order,
    input wire in_valid,
    input wire [`MFP_OCTET_W-1:0] in_octet,
    output reg in_ready,
    output reg ser_bit,
    output reg ser_valid
);
    reg [`MFP_OCTET_W-1:0] shift;
    reg [`MFP_BITPOS_W-1:0] count;
    reg busy;
    reg msb_first;

    // ==========================================================
    // Shifter
    always @(posedge clk) begin
        if (rst) begin
            shift <= 8'h00;
            count <= 3'h0;
            busy <= 1'b0;
            msb_first <= 1'b0;
            in_ready <= 1'b1;
            ser_bit <= 1'b0;
            ser_valid <= 1'b0;
        end else if (ce) begin
            if (busy) begin
                // Octet value untouched; only bit order differs
                ser_bit <= msb_first ? shift[7] : shift[0];
                ser_valid <= 1'b1;
                shift <= msb_first ? {shift[6:0], 1'b0} : {1'b0, shift[7:1]};
                count <= count + 3'h1;
                if (count == 3'h7) begin
                    busy <= 1'b0;
                    in_ready <= 1'b1;
                end
            end else begin
                ser_valid <= 1'b0;
                if (in_valid) begin
                    shift <= in_octet;
                    msb_first <= order;
                    count <= 3'h0;
                    busy <= 1'b1;
                    in_ready <= 1'b0;
                end
            end
        end
    end
endmodule

// ---- hdl/mfp_packer.v ----
// Message field packer: packs variable-width fields into octets, pads,
// numbers them and hands them to a serialiser and an octet output port.
// Assumes the producer presents fields with valid/ready on CLK, header
// unit first, then the message unit, each closed by a last flag.
// A FIELD_LEN above 32 packs the bits above the 32 data bits as zeros.
//
// Functional notes
// - After the last field, unused bits of the final octet are zero.
// - Each unit is padded alone; next unit starts at bit zero of new octet.
// - Serial output sends octet 0 first, each octet bit weight one first if BIT_ORDER low, weight 128 first if high.
// - Header octets are emitted first, then message octets directly after.
// - Octets leave as a plain ordered stream independent of medium order.
// - Medium bit order is applied only in the serialiser; octets unchanged.
// - Field LSB goes to lowest free octet bit, overflow into next octet.
// - Groups of a field are packed in listed order, same placement.
// - Octets numbered in emission order; each unit starts at zero.
`timescale 1ns/1ns
`include "mfp_map.vh"

module mfp_packer (
    input wire CLK,
    input wire RST,
    input wire CE,
    input wire BIT_ORDER,
    input wire FIELD_VALID,
    input wire [`MFP_FIELD_W-1:0] FIELD_DATA,
    input wire [`MFP_LEN_W-1:0] FIELD_LEN,
    input wire [`MFP_KIND_W-1:0] FIELD_KIND,
    input wire FIELD_GATED,
    input wire FIELD_PRESENCE_FLAG,
    input wire GROUP_PRESENCE_FLAG,
    input wire FIELD_LAST,
    output reg FIELD_READY,
    output reg [`MFP_OCTET_W-1:0] OCTET,
    output reg OCTET_VALID,
    output reg [`MFP_OCTNUM_W-1:0] OCTET_NUM,
    output reg OCTET_FIRST,
    output reg OCTET_LAST,
    output reg OCTET_HDR,
    output reg SER_BIT,
    output reg SER_VALID
);
    // One-hot packing states
    localparam ST_IDLE = 4'h1;
    localparam ST_BITS = 4'h2;
    localparam ST_EMIT = 4'h4;
    localparam ST_WAIT = 4'h8;

    reg [3:0] state;
    reg [`MFP_FIELD_W:0] bits;
    reg [`MFP_LEN_W:0] remain;
    reg [`MFP_OCTET_W-1:0] acc;
    reg [`MFP_BITPOS_W:0] fill;
    reg unit_last;
    reg unit_hdr;
    reg emit_last;
    reg [`MFP_OCTNUM_W-1:0] num;
    reg ser_in_valid;
    reg [`MFP_OCTET_W-1:0] ser_octet;
    wire ser_ready;
    wire ser_bit_w;
    wire ser_valid_w;
    wire skip;
    wire [`MFP_LEN_W:0] eff_len;

    // ==========================================================
    // Request decode
    // Bits one request occupies in the stream
    function [`MFP_LEN_W:0] span;
        input [`MFP_LEN_W-1:0] len;
        input gated;
        input skipped;
        if (!gated) begin
            span = {1'b0, len};
        end else if (skipped) begin
            span = 7'h01;
        end else begin
            span = {1'b0, len} + 7'h01;
        end
    endfunction

    // Shift image: if gated, flag bit lowest with all 32 data bits above it; else data from bit zero
    function [`MFP_FIELD_W:0] image;
        input [`MFP_FIELD_W-1:0] data;
        input gated;
        input skipped;
        if (gated) begin
            image = {data, ~skipped};
        end else begin
            image = {1'b0, data};
        end
    endfunction

    // Presence gating: a gated field whose field and group presence flags are both zero contributes only the flag
    assign skip = FIELD_GATED & ~(FIELD_PRESENCE_FLAG | GROUP_PRESENCE_FLAG);
    assign eff_len = span(FIELD_LEN, FIELD_GATED, skip);

    // ==========================================================
    // Packing state machine
    // One bit per enabled cycle; a full octet is held in ST_WAIT until the
    // serialiser takes it, so FIELD_READY stays low meanwhile.
    always @(posedge CLK) begin
        if (RST) begin
            state <= ST_IDLE;
            bits <= 33'h0;
            remain <= 7'h00;
            acc <= 8'h00;
            fill <= 4'h0;
            unit_last <= 1'b0;
            unit_hdr <= 1'b1;
            emit_last <= 1'b0;
            num <= 16'h0000;
            FIELD_READY <= 1'b0;
            OCTET <= 8'h00;
            OCTET_VALID <= 1'b0;
            OCTET_NUM <= 16'h0000;
            OCTET_FIRST <= 1'b0;
            OCTET_LAST <= 1'b0;
            OCTET_HDR <= 1'b0;
            ser_in_valid <= 1'b0;
            ser_octet <= 8'h00;
        end else if (CE) begin
            OCTET_VALID <= 1'b0;
            case (state)
                ST_IDLE: begin
                    FIELD_READY <= 1'b1;
                    if (FIELD_VALID && FIELD_READY) begin
                        FIELD_READY <= 1'b0;
                        // Groups arrive as successive requests in listed order
                        bits <= image(FIELD_DATA, FIELD_GATED, skip);
                        remain <= eff_len;
                        unit_last <= FIELD_LAST;
                        unit_hdr <= (FIELD_KIND == `MFP_KIND_HDR);
                        state <= ST_BITS;
                    end
                end
                ST_BITS: begin
                    if (remain != 7'h00) begin
                        // LSB of field into lowest free bit
                        acc[fill[2:0]] <= bits[0];
                        bits <= {1'b0, bits[`MFP_FIELD_W:1]};
                        remain <= remain - 7'h01;
                        fill <= fill + 4'h1;
                        if (fill == 4'h7) begin
                            emit_last <= unit_last && (remain == 7'h01);
                            state <= ST_EMIT;
                        end
                    end else if (unit_last && fill != 4'h0) begin
                        // Unused high bits stay zero from the cleared accumulator
                        emit_last <= 1'b1;
                        state <= ST_EMIT;
                    end else if (unit_last) begin
                        // Limitation: a zero-length last field right after an exact
                        // fill leaves the previous octet without OCTET_LAST.
                        // Unit ended on a boundary: restart numbering
                        num <= 16'h0000;
                        state <= ST_IDLE;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                ST_EMIT: begin
                    if (!ser_in_valid) begin
                        // Plain ordered octet stream, header unit first
                        OCTET <= acc;
                        OCTET_VALID <= 1'b1;
                        OCTET_NUM <= num;
                        OCTET_FIRST <= (num == 16'h0000);
                        OCTET_LAST <= emit_last;
                        OCTET_HDR <= unit_hdr;
                        ser_octet <= acc;
                        ser_in_valid <= 1'b1;
                        acc <= 8'h00;
                        fill <= 4'h0;
                        num <= emit_last ? 16'h0000 : num + 16'h0001;
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (ser_in_valid && ser_ready) begin
                        ser_in_valid <= 1'b0;
                        if (emit_last) begin
                            emit_last <= 1'b0;
                            state <= ST_IDLE;
                        end else begin
                            state <= ST_BITS;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Serial output
    // Octets are offered one at a time; the copy below keeps outputs on flops
    mfp_serialiser u_ser (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .order(BIT_ORDER),
        .in_valid(ser_in_valid),
        .in_octet(ser_octet),
        .in_ready(ser_ready),
        .ser_bit(ser_bit_w),
        .ser_valid(ser_valid_w)
    );

    always @(posedge CLK) begin
        if (RST) begin
            SER_BIT <= 1'b0;
            SER_VALID <= 1'b0;
        end else if (CE) begin
            SER_BIT <= ser_bit_w;
            SER_VALID <= ser_valid_w;
        end
    end
endmodule

// ---- verification/mfp_packer_asserts.sv ----
// Checker for the field packer: take, octet numbering, serial timing.
// Assumes CE held high; bound to every mfp_packer.
`timescale 1ns/1ns
module mfp_chk (
    input wire CLK,
    input wire RST,
    input wire BIT_ORDER,
    input wire FIELD_VALID,
    input wire FIELD_READY,
    input wire [7:0] OCTET,
    input wire OCTET_VALID,
    input wire [15:0] OCTET_NUM,
    input wire OCTET_FIRST,
    input wire OCTET_LAST,
    input wire SER_BIT,
    input wire SER_VALID
);
    reg [15:0] prev_num;
    reg [7:0] held;
    reg after_last;
    always @(posedge CLK) begin
        if (RST) begin
            prev_num <= 16'h0;
            held <= 8'h0;
            after_last <= 1'b1;
        end else if (OCTET_VALID) begin
            prev_num <= OCTET_NUM;
            held <= OCTET;
            after_last <= OCTET_LAST;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    a_take_drops: assert property (FIELD_VALID && FIELD_READY |=> !FIELD_READY)
        else $error("ready held after take");
    a_first_zero: assert property (OCTET_VALID && (after_last || OCTET_FIRST) |->
        OCTET_FIRST && OCTET_NUM == 16'h0)
        else $error("first octet not zero");
    a_num_step: assert property (OCTET_VALID && !OCTET_FIRST |-> OCTET_NUM == prev_num + 16'h1)
        else $error("octet number skipped");
    a_octet_pulse: assert property (OCTET_VALID |=> !OCTET_VALID)
        else $error("octet valid too long");
    a_ser_follows: assert property (OCTET_VALID |-> ##[3:8] $rose(SER_VALID))
        else $error("serial late");
    a_ser_span: assert property ($rose(SER_VALID) |-> SER_VALID [*8])
        else $error("serial octet short");
    a_lsb_first: assert property ($rose(SER_VALID) && !BIT_ORDER |-> SER_BIT == held[0])
        else $error("first bit not weight one");
    a_msb_first: assert property ($rose(SER_VALID) && BIT_ORDER |-> SER_BIT == held[7])
        else $error("first bit not weight 128");
endmodule
bind mfp_packer mfp_chk chk (.CLK, .RST, .BIT_ORDER, .FIELD_VALID, .FIELD_READY, .OCTET,
    .OCTET_VALID, .OCTET_NUM, .OCTET_FIRST, .OCTET_LAST, .SER_BIT, .SER_VALID);

// ---- verification/mfp_sink.sv ----
// Lower layer model: records each octet and rebuilds serial octets.
// Assumes BIT_ORDER stays put while a unit is in flight.
`timescale 1ns/1ns
module mfp_sink (
    input wire CLK,
    input wire BIT_ORDER,
    input wire [7:0] OCTET,
    input wire OCTET_VALID,
    input wire [15:0] OCTET_NUM,
    input wire OCTET_FIRST,
    input wire OCTET_LAST,
    input wire OCTET_HDR,
    input wire SER_BIT,
    input wire SER_VALID
);
    logic [26:0] got[$];
    logic [7:0] ser[$];
    logic [7:0] sh = 8'h0;
    int n = 0;
    always @(posedge CLK) begin
        if (OCTET_VALID)
            got.push_back({OCTET_HDR, OCTET_FIRST, OCTET_LAST, OCTET_NUM, OCTET});
        if (SER_VALID) begin
            sh = BIT_ORDER ? {sh[6:0], SER_BIT} : {SER_BIT, sh[7:1]};
            n++;
            if (n == 8) begin
                ser.push_back(sh);
                n = 0;
            end
        end
    end
endmodule

// ---- verification/tb.sv ----
// Bench for the field packer: example message, then random PDUs.
// Assumes mfp_sink as far side and the bound checker.
`timescale 1ns/1ns
`include "mfp_map.vh"
module tb;
    localparam bit [1:0] HK = `MFP_KIND_HDR, MK = `MFP_KIND_MSG;
    reg CLK = 1'h0, RST = 1'h1, CE = 1'h1, BIT_ORDER = 1'h0, FIELD_VALID = 1'h0;
    reg FIELD_GATED = 1'h0, FIELD_PRESENCE_FLAG = 1'h0, GROUP_PRESENCE_FLAG = 1'h0;
    reg FIELD_LAST = 1'h0;
    reg [31:0] FIELD_DATA = 32'h0;
    reg [5:0] FIELD_LEN = 6'h0;
    reg [1:0] FIELD_KIND = 2'h0;
    wire FIELD_READY, OCTET_VALID, OCTET_FIRST, OCTET_LAST, OCTET_HDR, SER_BIT, SER_VALID;
    wire [7:0] OCTET;
    wire [15:0] OCTET_NUM;
    int miscompares = 0, cmp_count = 0, cyc = 0;
    logic eb[$];
    logic [26:0] exq[$];
    logic [26:0] e;
    mfp_packer dut (.CLK, .RST, .CE, .BIT_ORDER, .FIELD_VALID, .FIELD_DATA, .FIELD_LEN,
        .FIELD_KIND, .FIELD_GATED, .FIELD_PRESENCE_FLAG, .GROUP_PRESENCE_FLAG, .FIELD_LAST,
        .FIELD_READY, .OCTET, .OCTET_VALID, .OCTET_NUM, .OCTET_FIRST, .OCTET_LAST,
        .OCTET_HDR, .SER_BIT, .SER_VALID);
    mfp_sink sink (.CLK, .BIT_ORDER, .OCTET, .OCTET_VALID, .OCTET_NUM, .OCTET_FIRST,
        .OCTET_LAST, .OCTET_HDR, .SER_BIT, .SER_VALID);
    initial forever #50 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            complete_run();
        end
    end
    task complete_run();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task check(input string nm, input logic [26:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task check_ser(input logic [7:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value serial expected %h seen %h", exp, got);
        end
    endtask
    function automatic [7:0] pack(input int b);
        for (int j = 0; j < 8; j++)
            pack[j] = eb[b + j];
    endfunction
    task send(input [31:0] d, input int n, input [1:0] k, input g, f, l);
        bit s;
        s = 1'($urandom);
        d = d & ~(32'hffffffff << n);
        if (g)
            eb.push_back(f);
        if (!g || f)
            for (int i = 0; i < n; i++)
                eb.push_back(d[i]);
        if (l) begin
            while (eb.size() % 8)
                eb.push_back(1'b0);
            for (int i = 0; i < eb.size(); i += 8)
                exq.push_back({k == HK, i == 0, i + 8 == eb.size(), 16'(i / 8), pack(i)});
            eb.delete();
        end
        FIELD_DATA <= d;
        FIELD_LEN <= n[5:0];
        FIELD_KIND <= k;
        FIELD_GATED <= g;
        FIELD_PRESENCE_FLAG <= f & s;
        GROUP_PRESENCE_FLAG <= f & !s;
        FIELD_LAST <= l;
        FIELD_VALID <= 1'h1;
        @(posedge CLK);
        while (FIELD_READY !== 1'h1)
            @(posedge CLK);
    endtask
    task drain();
        FIELD_VALID <= 1'h0;
        while (sink.got.size() < exq.size() || sink.ser.size() < exq.size())
            @(posedge CLK);
        repeat (12) @(posedge CLK);
        while (exq.size()) begin
            e = exq.pop_front();
            check("octet", e, sink.got.pop_front());
            check_ser(e[7:0], sink.ser.pop_front());
        end
        check("extra octets", 27'h0, 27'(sink.got.size() + sink.ser.size()));
    endtask
    task rand_unit(input [1:0] k, input int nf);
        for (int i = 0; i < nf; i++)
            send($urandom, 1 + $urandom % 32, k, 1'($urandom), 1'($urandom), i == nf - 1);
    endtask
    initial begin
        void'($urandom(32'h0b79));
        repeat (12) @(posedge CLK);
        RST <= 1'h0;
        @(posedge CLK);
        send(32'h3, 8, HK, 1'h0, 1'h0, 1'h1);
        send(32'h0, 5, MK, 1'h0, 1'h0, 1'h0);
        send(32'h42, 7, MK, 1'h1, 1'h1, 1'h0);
        send(32'h41, 7, MK, 1'h1, 1'h1, 1'h0);
        send(32'h4d2, 14, MK, 1'h0, 1'h0, 1'h0);
        send(32'h1fffff, 21, MK, 1'h1, 1'h0, 1'h0);
        send(32'h1f, 5, MK, 1'h1, 1'h0, 1'h0);
        send(32'h7f, 7, MK, 1'h1, 1'h0, 1'h0);
        send(32'hffffff, 24, MK, 1'h1, 1'h0, 1'h1);
        drain();
        for (int t = 0; t < 30; t++) begin
            BIT_ORDER <= 1'($urandom);
            rand_unit(HK, 1 + $urandom % 3);
            rand_unit(MK, 1 + $urandom % 6);
            drain();
        end
        complete_run();
    end
endmodule
